// [logic/uart_port_pkg.sv]
package uart_port_pkg;
    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W      = 3;
    localparam int DATA_W      = 8;
    localparam int FIFO_DEPTH  = 32;
    localparam int CNT_W       = 6;
    // ----------------------------------------------------------------
    // Register indices
    // ----------------------------------------------------------------
    localparam logic [2:0] REG_DATA   = 3'h0;
    localparam logic [2:0] REG_IRQEN  = 3'h1;
    localparam logic [2:0] REG_IRQID  = 3'h2;
    localparam logic [2:0] REG_MODEM  = 3'h4;
    localparam logic [2:0] REG_STATUS = 3'h5;
    localparam logic [2:0] REG_SCRATCH = 3'h7;
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int MODEM_IRQ_OE_BIT = 3;
    localparam int IRQEN_RX_BIT     = 0;
    localparam int IRQEN_TX_BIT     = 1;
    localparam int STAT_RX_BIT      = 0;
    localparam int STAT_TXE_BIT     = 5;
    localparam logic [7:0] MODEM_RST = 8'h00;
    localparam logic [7:0] IRQEN_RST = 8'h00;
    localparam logic [7:0] SCRATCH_RST = 8'h00;
    localparam logic [7:0] IRQID_NONE = 8'h01;
    localparam logic [7:0] IRQID_RX   = 8'h04;
    localparam logic [7:0] IRQID_TX   = 8'h02;
endpackage

// [logic/uart_chan_regs.sv]
`timescale 1ns/10ps
module uart_chan_regs
    import uart_port_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              rd_start_in,
    input  wire logic              wr_commit_in,
    input  wire logic              tx_drain_in,
    input  wire logic              rx_push_in,
    input  wire logic [DATA_W-1:0] rx_data_in,
    output logic      [DATA_W-1:0] rdata_out,
    output logic                   irq_out,
    output logic                   irq_oe_out,
    output logic                   tx_ready_n_out,
    output logic                   rx_ready_n_out
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] modem;
        logic [DATA_W-1:0] irqen;
        logic [DATA_W-1:0] scratch;
        logic [DATA_W-1:0] rdata;
        logic [CNT_W-1:0]  tx_cnt;
        logic [CNT_W-1:0]  rx_cnt;
        logic [4:0]        tx_wp;
        logic [4:0]        tx_rp;
        logic [4:0]        rx_wp;
        logic [4:0]        rx_rp;
    } chan_s;

    chan_s             st_r;
    chan_s             st_nxt;
    logic [DATA_W-1:0] tx_mem [DEPTH];
    logic [DATA_W-1:0] rx_mem [DEPTH];
    logic              tx_full;
    logic              rx_empty;
    logic              rx_pop;
    logic              tx_push;
    logic              irq_lvl;

    assign tx_full  = (st_r.tx_cnt == CNT_W'(DEPTH));
    assign rx_empty = (st_r.rx_cnt == '0);
    assign tx_push  = wr_commit_in && (addr_in == REG_DATA) && !tx_full;
    assign rx_pop   = rd_start_in && (addr_in == REG_DATA) && !rx_empty;
    assign irq_lvl  = (st_r.irqen[IRQEN_RX_BIT] && !rx_empty)
                    || (st_r.irqen[IRQEN_TX_BIT] && (st_r.tx_cnt == '0));

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic       tx_pop;
        logic       rx_ok;
        tx_pop = tx_drain_in && (st_r.tx_cnt != '0);
        rx_ok  = rx_push_in && (st_r.rx_cnt != CNT_W'(DEPTH));
        st_nxt = st_r;
        if (rd_start_in) begin
            case (addr_in)
                REG_DATA:    st_nxt.rdata = rx_empty ? '0 : rx_mem[st_r.rx_rp];
                REG_IRQEN:   st_nxt.irqen = st_r.irqen;
                REG_IRQID:   st_nxt.rdata = (!rx_empty && st_r.irqen[IRQEN_RX_BIT])
                                 ? IRQID_RX : (irq_lvl ? IRQID_TX : IRQID_NONE);
                REG_MODEM:   st_nxt.rdata = st_r.modem;
                REG_STATUS:  st_nxt.rdata = {2'h0, st_r.tx_cnt == '0, 4'h0, !rx_empty};
                REG_SCRATCH: st_nxt.rdata = st_r.scratch;
                default:     st_nxt.rdata = '0;
            endcase
            if (addr_in == REG_IRQEN) begin
                st_nxt.rdata = st_r.irqen;
            end
        end
        if (wr_commit_in) begin
            case (addr_in)
                REG_IRQEN:   st_nxt.irqen   = wdata_in;
                REG_MODEM:   st_nxt.modem   = wdata_in;
                REG_SCRATCH: st_nxt.scratch = wdata_in;
                default:     st_nxt.scratch = st_r.scratch;
            endcase
        end
        if (tx_push) begin
            st_nxt.tx_wp = st_r.tx_wp + 5'h1;
        end
        if (tx_pop) begin
            st_nxt.tx_rp = st_r.tx_rp + 5'h1;
        end
        st_nxt.tx_cnt = st_r.tx_cnt + CNT_W'(tx_push) - CNT_W'(tx_pop);
        if (rx_ok) begin
            st_nxt.rx_wp = st_r.rx_wp + 5'h1;
        end
        if (rx_pop) begin
            st_nxt.rx_rp = st_r.rx_rp + 5'h1;
        end
        st_nxt.rx_cnt = st_r.rx_cnt + CNT_W'(rx_ok) - CNT_W'(rx_pop);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r       <= '0;
            st_r.modem <= MODEM_RST;
            st_r.irqen <= IRQEN_RST;
            st_r.scratch <= SCRATCH_RST;
        end else begin
            st_r <= st_nxt;
        end
        if (tx_push) begin
            tx_mem[st_r.tx_wp] <= wdata_in;
        end
        if (rx_push_in && (st_r.rx_cnt != CNT_W'(DEPTH))) begin
            rx_mem[st_r.rx_wp] <= rx_data_in;
        end
    end

    assign rdata_out      = st_r.rdata;
    assign irq_out        = irq_lvl;
    assign irq_oe_out     = st_r.modem[MODEM_IRQ_OE_BIT];
    assign tx_ready_n_out = tx_full;
    assign rx_ready_n_out = rx_empty;
endmodule

// [logic/dual_uart_host_bus_port.sv]
`timescale 1ns/10ps
module dual_uart_host_bus_port
    import uart_port_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe_out,
    input  wire logic              read_strobe_n_in,
    input  wire logic              write_strobe_n_in,
    input  wire logic              chan_a_select_n_in,
    input  wire logic              chan_b_select_n_in,
    input  wire logic [1:0]        tx_drain_in,
    input  wire logic [1:0]        rx_push_in,
    input  wire logic [DATA_W-1:0] rx_data_in,
    output logic                   chan_a_irq_out,
    output logic                   chan_a_irq_oe_out,
    output logic                   chan_b_irq_out,
    output logic                   chan_b_irq_oe_out,
    output logic                   chan_a_user_out2_n_out,
    output logic                   chan_b_user_out2_n_out,
    output logic                   chan_a_tx_ready_n_out,
    output logic                   chan_a_rx_ready_n_out,
    output logic                   chan_b_tx_ready_n_out,
    output logic                   chan_b_rx_ready_n_out
);
    // ----------------------------------------------------------------
    // Pin synchronisers and state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]        rd_sync;
        logic [2:0]        wr_sync;
        logic [2:0]        csa_sync;
        logic [2:0]        csb_sync;
        logic              rd_lvl;
        logic              wr_lvl;
        logic              csa_lvl;
        logic              csb_lvl;
        logic [1:0]        rd_chan;
        logic [1:0]        wr_chan;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
        logic              oe;
        logic [DATA_W-1:0] dout;
        logic [1:0]        irq;
        logic [1:0]        irq_oe;
        logic [1:0]        out2_n;
        logic [1:0]        txr_n;
        logic [1:0]        rxr_n;
    } port_s;

    port_s             st_r;
    port_s             st_nxt;
    logic [1:0]        rd_start;
    logic [1:0]        wr_commit;
    logic [DATA_W-1:0] ch_rdata [2];
    logic [1:0]        ch_irq;
    logic [1:0]        ch_irq_oe;
    logic [1:0]        ch_txr_n;
    logic [1:0]        ch_rxr_n;
    logic              rd_fall;
    logic              wr_rise;
    logic              wr_fall;
    logic [1:0]        sel_n_now;

    // Stage 2 and 3 agreement marks a settled level
    assign rd_fall = st_r.rd_lvl && (st_r.rd_sync[2:1] == 2'b00);
    assign wr_fall = st_r.wr_lvl && (st_r.wr_sync[2:1] == 2'b00);
    assign wr_rise = !st_r.wr_lvl && (st_r.wr_sync[2:1] == 2'b11);

    // Select level settled at this edge, even when it moved with the strobe
    assign sel_n_now[0] = (st_r.csa_sync[2] == st_r.csa_sync[1])
                        ? st_r.csa_sync[2] : st_r.csa_lvl;
    assign sel_n_now[1] = (st_r.csb_sync[2] == st_r.csb_sync[1])
                        ? st_r.csb_sync[2] : st_r.csb_lvl;

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_chan
        assign rd_start[c]  = rd_fall && !sel_n_now[c];
        assign wr_commit[c] = wr_rise && st_r.wr_chan[c];
        uart_chan_regs #(
            .DEPTH (DEPTH)
        ) u_chan (
            .clk_in         (clk_in),
            .rst_in         (rst_in),
            .addr_in        (wr_commit[c] ? st_r.wr_addr : addr_in),
            .wdata_in       (st_r.wr_data),
            .rd_start_in    (rd_start[c]),
            .wr_commit_in   (wr_commit[c]),
            .tx_drain_in    (tx_drain_in[c]),
            .rx_push_in     (rx_push_in[c]),
            .rx_data_in     (rx_data_in),
            .rdata_out      (ch_rdata[c]),
            .irq_out        (ch_irq[c]),
            .irq_oe_out     (ch_irq_oe[c]),
            .tx_ready_n_out (ch_txr_n[c]),
            .rx_ready_n_out (ch_rxr_n[c])
        );
    end

    // ----------------------------------------------------------------
    // Bus sequencing
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt          = st_r;
        st_nxt.rd_sync  = {st_r.rd_sync[1:0], read_strobe_n_in};
        st_nxt.wr_sync  = {st_r.wr_sync[1:0], write_strobe_n_in};
        st_nxt.csa_sync = {st_r.csa_sync[1:0], chan_a_select_n_in};
        st_nxt.csb_sync = {st_r.csb_sync[1:0], chan_b_select_n_in};
        if (st_r.rd_sync[2] == st_r.rd_sync[1]) begin
            st_nxt.rd_lvl = st_r.rd_sync[2];
        end
        if (st_r.wr_sync[2] == st_r.wr_sync[1]) begin
            st_nxt.wr_lvl = st_r.wr_sync[2];
        end
        if (st_r.csa_sync[2] == st_r.csa_sync[1]) begin
            st_nxt.csa_lvl = st_r.csa_sync[2];
        end
        if (st_r.csb_sync[2] == st_r.csb_sync[1]) begin
            st_nxt.csb_lvl = st_r.csb_sync[2];
        end
        if (rd_fall) begin
            st_nxt.rd_chan = rd_start;
        end
        if (!st_r.rd_lvl && st_r.rd_sync[2:1] == 2'b11) begin
            st_nxt.rd_chan = 2'b00;
        end
        if (wr_fall) begin
            st_nxt.wr_chan = ~sel_n_now;
        end
        if (!st_r.wr_lvl) begin
            st_nxt.wr_addr = addr_in;
            st_nxt.wr_data = data_in;
        end
        if (wr_rise) begin
            st_nxt.wr_chan = 2'b00;
        end
        st_nxt.oe   = (st_r.rd_chan != 2'b00);
        st_nxt.dout = st_r.rd_chan[1] ? ch_rdata[1] : ch_rdata[0];
        st_nxt.irq    = ch_irq;
        st_nxt.irq_oe = ch_irq_oe;
        st_nxt.out2_n = ~ch_irq_oe;
        st_nxt.txr_n  = ch_txr_n;
        st_nxt.rxr_n  = ch_rxr_n;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r          <= '0;
            st_r.rd_sync  <= 3'h7;
            st_r.wr_sync  <= 3'h7;
            st_r.csa_sync <= 3'h7;
            st_r.csb_sync <= 3'h7;
            st_r.rd_lvl   <= 1'b1;
            st_r.wr_lvl   <= 1'b1;
            st_r.csa_lvl  <= 1'b1;
            st_r.csb_lvl  <= 1'b1;
            st_r.out2_n   <= 2'h3;
            st_r.txr_n    <= 2'h0;
            st_r.rxr_n    <= 2'h3;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign data_out               = st_r.dout;
    assign data_oe_out            = st_r.oe;
    assign chan_a_irq_out         = st_r.irq[0];
    assign chan_b_irq_out         = st_r.irq[1];
    assign chan_a_irq_oe_out      = st_r.irq_oe[0];
    assign chan_b_irq_oe_out      = st_r.irq_oe[1];
    assign chan_a_user_out2_n_out = st_r.out2_n[0];
    assign chan_b_user_out2_n_out = st_r.out2_n[1];
    assign chan_a_tx_ready_n_out  = st_r.txr_n[0];
    assign chan_a_rx_ready_n_out  = st_r.rxr_n[0];
    assign chan_b_tx_ready_n_out  = st_r.txr_n[1];
    assign chan_b_rx_ready_n_out  = st_r.rxr_n[1];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_OUT2_A: assert property (@(posedge clk_in) disable iff (rst_in)
        chan_a_irq_oe_out |-> !chan_a_user_out2_n_out)
        else $error("out2 A not low while irq A driven");
    AST_OUT2_FLOAT_A: assert property (@(posedge clk_in) disable iff (rst_in)
        !chan_a_irq_oe_out |-> chan_a_user_out2_n_out)
        else $error("out2 A not high while irq A floats");
    AST_OUT2_B: assert property (@(posedge clk_in) disable iff (rst_in)
        chan_b_irq_oe_out != chan_b_user_out2_n_out)
        else $error("out2 B disagrees with irq B mode");
    AST_OE_READ: assert property (@(posedge clk_in) disable iff (rst_in)
        data_oe_out |-> $past(st_r.rd_chan != 2'b00))
        else $error("data driven outside a read");
    AST_READ_DRIVE: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_fall && !sel_n_now[0] |=> ##1 data_oe_out)
        else $error("selected read did not drive bus");
    AST_READ_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
        data_oe_out && st_r.rd_lvl == 1'b0 |=> data_oe_out)
        else $error("read data dropped before strobe rise");
    AST_NO_SEL: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_fall && (sel_n_now == 2'b11) |=> ##1 !data_oe_out)
        else $error("unselected read drove bus");
    AST_WR_SEL_B: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_commit[1] |-> $past(st_r.wr_chan[1]))
        else $error("channel B written without select");
    AST_RXR_A: assert property (@(posedge clk_in) disable iff (rst_in)
        rx_push_in[0] && st_r.rxr_n[0] && !rd_start[0] |=> ##1 !chan_a_rx_ready_n_out)
        else $error("rx ready A not shown after byte");
endmodule

// [bench/host_bus_model.sv]
`timescale 1ns/10ps
module host_bus_model
    import uart_port_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic [DATA_W-1:0] dev_data_in,
    input  wire logic              dev_oe_in,
    output logic      [DATA_W-1:0] bus_out,
    output logic      [ADDR_W-1:0] addr_out,
    output logic                   read_strobe_n_out,
    output logic                   write_strobe_n_out,
    output logic                   chan_a_select_n_out,
    output logic                   chan_b_select_n_out
);
    logic [DATA_W-1:0] drv_r;
    logic              drv_en_r;
    logic [DATA_W-1:0] last_r;
    initial begin
        drv_r = 8'h00;
        drv_en_r = 1'b0;
        last_r = 8'h00;
        addr_out = 3'h0;
        read_strobe_n_out = 1'b1;
        write_strobe_n_out = 1'b1;
        chan_a_select_n_out = 1'b1;
        chan_b_select_n_out = 1'b1;
    end
    // ----------------------------------------------------------------
    // Bus level, released bus shows inverse of last level
    // ----------------------------------------------------------------
    always_comb begin
        if (dev_oe_in) begin
            bus_out = dev_data_in;
        end else if (drv_en_r) begin
            bus_out = drv_r;
        end else begin
            bus_out = ~last_r;
        end
    end
    always @(posedge clk_in) begin
        last_r <= bus_out;
    end
    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    task automatic bus_write(input logic [1:0] sel_n, input logic [ADDR_W-1:0] addr,
                             input logic [DATA_W-1:0] data);
        @(negedge clk_in);
        {chan_b_select_n_out, chan_a_select_n_out} = sel_n;
        addr_out = addr;
        drv_r = data;
        drv_en_r = 1'b1;
        write_strobe_n_out = 1'b0;
        repeat (5) @(negedge clk_in);
        write_strobe_n_out = 1'b1;
        repeat (6) @(negedge clk_in);
        drv_en_r = 1'b0;
        {chan_b_select_n_out, chan_a_select_n_out} = 2'b11;
    endtask
    task automatic bus_read(input logic [1:0] sel_n, input logic [ADDR_W-1:0] addr,
                            output logic [DATA_W-1:0] data, output logic seen);
        int n;
        @(negedge clk_in);
        {chan_b_select_n_out, chan_a_select_n_out} = sel_n;
        addr_out = addr;
        read_strobe_n_out = 1'b0;
        n = 0;
        seen = 1'b0;
        while (seen == 1'b0 && n < 12) begin
            @(negedge clk_in);
            seen = (dev_oe_in === 1'b1);
            n++;
        end
        data = bus_out;
        read_strobe_n_out = 1'b1;
        n = 0;
        while (dev_oe_in !== 1'b0 && n < 10) begin
            @(negedge clk_in);
            n++;
        end
        repeat (3) @(negedge clk_in);
        {chan_b_select_n_out, chan_a_select_n_out} = 2'b11;
    endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/10ps
module tb;
    import uart_port_pkg::*;
    logic              clk_in = 1'b0;
    logic              rst_in = 1'b1;
    logic [DATA_W-1:0] bus;
    logic [DATA_W-1:0] data_out;
    logic              data_oe_out;
    logic [ADDR_W-1:0] addr;
    logic              rd_n;
    logic              wr_n;
    logic              sel_a_n;
    logic              sel_b_n;
    logic [1:0]        tx_drain = 2'b00;
    logic [1:0]        rx_push = 2'b00;
    logic [DATA_W-1:0] rx_data = 8'h00;
    logic [1:0]        irq;
    logic [1:0]        irq_oe;
    logic [1:0]        out2_n;
    logic [1:0]        tx_rdy_n;
    logic [1:0]        rx_rdy_n;
    int                n_errors = 0;
    int                check_count = 0;
    int                cycles = 0;
    logic [7:0]        rd;
    logic              seen;
    always #10 clk_in = ~clk_in;
    host_bus_model host (.clk_in(clk_in), .dev_data_in(data_out), .dev_oe_in(data_oe_out),
        .bus_out(bus), .addr_out(addr), .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n),
        .chan_a_select_n_out(sel_a_n), .chan_b_select_n_out(sel_b_n));
    dual_uart_host_bus_port #(.DEPTH(FIFO_DEPTH)) uut (.clk_in(clk_in), .rst_in(rst_in),
        .addr_in(addr), .data_in(bus), .data_out(data_out), .data_oe_out(data_oe_out),
        .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .chan_a_select_n_in(sel_a_n),
        .chan_b_select_n_in(sel_b_n), .tx_drain_in(tx_drain), .rx_push_in(rx_push),
        .rx_data_in(rx_data), .chan_a_irq_out(irq[0]), .chan_a_irq_oe_out(irq_oe[0]),
        .chan_b_irq_out(irq[1]), .chan_b_irq_oe_out(irq_oe[1]),
        .chan_a_user_out2_n_out(out2_n[0]), .chan_b_user_out2_n_out(out2_n[1]),
        .chan_a_tx_ready_n_out(tx_rdy_n[0]), .chan_a_rx_ready_n_out(rx_rdy_n[0]),
        .chan_b_tx_ready_n_out(tx_rdy_n[1]), .chan_b_rx_ready_n_out(rx_rdy_n[1]));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [1:0] sel_of(input int ch);
        return (ch == 0) ? 2'b10 : 2'b01;
    endfunction
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            $display("ERROR timeout expected finish seen hang");
            give_verdict();
        end
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check("data_oe", 8'h00, {7'h00, data_oe_out});
        check("irq_oe", 8'h00, {6'h00, irq_oe});
        check("out2_n", 8'h03, {6'h00, out2_n});
        check("tx_rdy_n", 8'h00, {6'h00, tx_rdy_n});
        check("rx_rdy_n", 8'h03, {6'h00, rx_rdy_n});
    endtask
    task automatic t_regs();
        host.bus_write(2'b10, REG_SCRATCH, 8'h5A);
        host.bus_write(2'b01, REG_SCRATCH, 8'hA5);
        host.bus_write(2'b01, REG_IRQEN, 8'h03);
        check("irq", 8'h02, {6'h00, irq});
        host.bus_read(2'b10, REG_SCRATCH, rd, seen);
        check("scratch_a", 8'h5A, rd);
        host.bus_read(2'b01, REG_SCRATCH, rd, seen);
        check("scratch_b", 8'hA5, rd);
        host.bus_read(2'b01, REG_IRQEN, rd, seen);
        check("irqen_b", 8'h03, rd);
        host.bus_read(2'b10, REG_IRQEN, rd, seen);
        check("irqen_a", IRQEN_RST, rd);
    endtask
    task automatic t_unselected();
        host.bus_write(2'b11, REG_SCRATCH, 8'hFF);
        host.bus_read(2'b11, REG_SCRATCH, rd, seen);
        check("oe_unsel", 8'h00, {7'h00, seen});
        host.bus_read(2'b10, REG_SCRATCH, rd, seen);
        check("scratch_a_kept", 8'h5A, rd);
        host.bus_read(2'b01, REG_SCRATCH, rd, seen);
        check("scratch_b_kept", 8'hA5, rd);
    endtask
    task automatic t_modem();
        for (int ch = 0; ch < 2; ch++) begin
            host.bus_write(sel_of(ch), REG_MODEM, 8'h08);
            check("irq_oe_set", (ch == 0) ? 8'h01 : 8'h02, {6'h00, irq_oe});
            check("out2_set", (ch == 0) ? 8'h02 : 8'h01, {6'h00, out2_n});
            host.bus_write(sel_of(ch), REG_MODEM, MODEM_RST);
            check("irq_oe_clr", 8'h00, {6'h00, irq_oe});
            check("out2_clr", 8'h03, {6'h00, out2_n});
        end
    endtask
    task automatic t_tx_fill();
        for (int ch = 0; ch < 2; ch++) begin
            for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                host.bus_write(sel_of(ch), REG_DATA, 8'(i));
            end
            check("tx_rdy_n_almost", 8'h00, {7'h00, tx_rdy_n[ch]});
            host.bus_write(sel_of(ch), REG_DATA, 8'h7E);
            check("tx_rdy_n_full", 8'h01, {7'h00, tx_rdy_n[ch]});
            check("tx_rdy_n_other", 8'h00, {7'h00, tx_rdy_n[1-ch]});
            @(negedge clk_in);
            tx_drain[ch] = 1'b1;
            @(negedge clk_in);
            tx_drain[ch] = 1'b0;
            repeat (2) @(negedge clk_in);
            check("tx_rdy_n_drain", 8'h00, {7'h00, tx_rdy_n[ch]});
            for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                @(negedge clk_in);
                tx_drain[ch] = 1'b1;
            end
            @(negedge clk_in);
            tx_drain[ch] = 1'b0;
        end
    endtask
    task automatic t_rx();
        for (int ch = 0; ch < 2; ch++) begin
            @(negedge clk_in);
            rx_data = (ch == 0) ? 8'hC3 : 8'h3C;
            rx_push[ch] = 1'b1;
            @(negedge clk_in);
            rx_push[ch] = 1'b0;
            repeat (2) @(negedge clk_in);
            check("rx_rdy_n_push", (ch == 0) ? 8'h02 : 8'h01, {6'h00, rx_rdy_n});
            host.bus_read(sel_of(ch), REG_DATA, rd, seen);
            check("rx_byte", (ch == 0) ? 8'hC3 : 8'h3C, rd);
            check("rx_rdy_n_pop", 8'h03, {6'h00, rx_rdy_n});
        end
    endtask
    initial begin
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (6) @(negedge clk_in);
        t_reset();
        t_regs();
        t_unselected();
        t_modem();
        t_tx_fill();
        t_rx();
        give_verdict();
    end
endmodule
